// ==== hw/msr_tout_pkg.sv ====
// package: register map, field positions and constants of the modem/timeout block
package msr_tout_pkg;
	localparam logic [7:0] MODEM_STATUS_OFS  = 8'h18;
	localparam logic [7:0] RX_TIMEOUT_OFS    = 8'h1c;
	localparam logic [7:0] IRQ_ENABLE_OFS    = 8'h20;
	localparam logic [7:0] CONTROL_OFS       = 8'h24;
	localparam logic [7:0] EVT_STATUS_OFS    = 8'h28;
	localparam logic [7:0] EVT_CLEAR_OFS     = 8'h2c;
	localparam logic [7:0] EVT_ENABLE_OFS    = 8'h30;
	localparam logic [31:0] MODEM_STATUS_RST = 32'h0000_0000;
	localparam logic [7:0] RX_TIMEOUT_RST    = 8'h00;
	localparam int MSR_CTS_BIT     = 4;
	localparam int MSR_CHG_BIT     = 0;
	localparam int TOR_EN_BIT      = 7;
	localparam int TOR_CMP_MSB     = 6;
	localparam int IER_TOUT_BIT    = 0;
	localparam int IER_MSI_BIT     = 3;
	localparam int CTL_LOOP_BIT    = 0;
	localparam int CTL_RTS_BIT     = 1;
	localparam int EVT_MSI_BIT     = 0;
	localparam int EVT_TOUT_BIT    = 1;
	localparam int EVT_W           = 2;
	localparam int CNT_W           = 7;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== hw/cts_if.sv ====
// interface: cts sampling signals between top and the change detector
`timescale 1ns/1ps
interface cts_if;
	logic cts_level;   // synchronised cts (1 = asserted)
	logic cts_changed; // one-cycle pulse per level change
	modport detector(output cts_level, output cts_changed);
	modport user(input cts_level, input cts_changed);
endinterface

// ==== hw/cts_sync.sv ====
// module: two-flop synchroniser and change detector for the clear-to-send input
`timescale 1ns/1ps
module cts_sync
	import msr_tout_pkg::*;
(
	input  wire logic clk_in,      // system clock
	input  wire logic rst_in,      // sync reset, high
	input  wire logic cts_raw_in,  // cts, active low, async
	cts_if.detector   cts          // synchronised level and change
);
	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	// next values: meta read only by stable
	always_comb begin
		next_meta   = ~cts_raw_in;
		next_stable = meta;
		next_prev   = stable;
	end

	// register stages; reset to deasserted so no false change
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end else begin
			meta   <= next_meta;
			stable <= next_stable;
			prev   <= next_prev;
		end
	end

	assign cts.cts_level   = stable;
	assign cts.cts_changed = stable ^ prev;

	AST_ONE_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
		cts.cts_changed |=> !cts.cts_changed)
		else $error("cts change pulse lasted more than one cycle");
endmodule // cts_sync

// ==== hw/rx_tout_timer.sv ====
// module: receive idle counter compared against the programmed count
`timescale 1ns/1ps
module rx_tout_timer
	import msr_tout_pkg::*;
(
	input  wire logic             clk_in,    // system clock
	input  wire logic             rst_in,    // sync reset, high
	input  wire logic             push_in,   // word pushed into rx fifo
	input  wire logic             empty_in,  // rx fifo empty
	input  wire logic             tick_in,   // baud tick
	input  wire logic [CNT_W-1:0] cmp_in,    // compare value
	output logic                  hit_out    // pulse when count reaches cmp
);
	logic [CNT_W-1:0] count;
	logic             armed;
	logic [CNT_W-1:0] next_count;
	logic             next_armed;

	// restart on push, count ticks; stop once matched so hit fires once
	always_comb begin
		next_count = count;
		next_armed = armed;
		hit_out    = 1'b0;
		if (push_in) begin
			next_count = '0;
			next_armed = 1'b1;
		end else if (empty_in) begin
			next_armed = 1'b0; // nothing left to time out on
		end else if (armed && count == cmp_in) begin
			hit_out    = 1'b1;
			next_armed = 1'b0;
		end else if (armed && tick_in) begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= '0;
			armed <= 1'b0;
		end else begin
			count <= next_count;
			armed <= next_armed;
		end
	end

	AST_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
		push_in |=> count == '0)
		else $error("counter did not restart on push");
endmodule // rx_tout_timer

// ==== hw/modem_tout_top.sv ====
// top: modem status and receive time-out logic with axi4-lite registers
`timescale 1ns/1ps
module modem_tout_top
	import msr_tout_pkg::*;
(
	input  wire logic        SYS_CLK_IN,      // 250 mhz clock
	input  wire logic        RST_IN,          // sync reset, high
	input  wire logic        CTS_N_IN,        // clear-to-send, low active
	output logic             RTS_N_OUT,       // request-to-send pin
	input  wire logic        RX_PUSH_IN,      // rx fifo push pulse
	input  wire logic        RX_EMPTY_IN,     // rx fifo empty level
	input  wire logic        BAUD_TICK_IN,    // baud-rate tick
	output logic             MSI_IRQ_OUT,     // modem status interrupt
	output logic             TOUT_IRQ_OUT,    // rx time-out interrupt
	output logic             IRQ_OUT,         // combined event interrupt
	input  wire logic [7:0]  AWADDR_IN,       // write address
	input  wire logic        AWVALID_IN,      // write address valid
	output logic             AWREADY_OUT,     // write address ready
	input  wire logic [31:0] WDATA_IN,        // write data
	input  wire logic [3:0]  WSTRB_IN,        // write strobes
	input  wire logic        WVALID_IN,       // write data valid
	output logic             WREADY_OUT,      // write data ready
	output logic [1:0]       BRESP_OUT,       // write response
	output logic             BVALID_OUT,      // write response valid
	input  wire logic        BREADY_IN,       // write response ready
	input  wire logic [7:0]  ARADDR_IN,       // read address
	input  wire logic        ARVALID_IN,      // read address valid
	output logic             ARREADY_OUT,     // read address ready
	output logic [31:0]      RDATA_OUT,       // read data
	output logic [1:0]       RRESP_OUT,       // read response
	output logic             RVALID_OUT,      // read data valid
	input  wire logic        RREADY_IN        // read data ready
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cts_if cts();

	logic [7:0]       aw_addr;
	logic             aw_held;
	logic [31:0]      w_data;
	logic             w_held;
	logic             bvalid;
	logic [1:0]       bresp;
	logic             rvalid;
	logic [31:0]      rdata;
	logic [1:0]       rresp;
	logic             chg_flag;
	logic [7:0]       rx_timeout_reg;
	logic [3:0]       irq_enable_reg;
	logic [1:0]       ctl;
	logic             tout_irq;
	logic [EVT_W-1:0] evt_sts;
	logic [EVT_W-1:0] evt_en;
	logic             tout_hit;
	logic             cts_raw;

	logic [7:0]       next_aw_addr;
	logic             next_aw_held;
	logic [31:0]      next_w_data;
	logic             next_w_held;
	logic             next_bvalid;
	logic [1:0]       next_bresp;
	logic             next_rvalid;
	logic [31:0]      next_rdata;
	logic [1:0]       next_rresp;
	logic             next_chg_flag;
	logic [7:0]       next_tor;
	logic [3:0]       next_ier;
	logic [1:0]       next_ctl;
	logic             next_tout_irq;
	logic [EVT_W-1:0] next_evt_sts;
	logic [EVT_W-1:0] next_evt_en;
	logic             do_wr;
	logic             do_rd;
	logic             msr_read;
	logic [EVT_W-1:0] evt_clr;
	logic [EVT_W-1:0] evt_set;
	logic             msi_irq;
	logic             loop_on;

	// ----------------------------------------------------------------
	// cts path and time-out counter
	// ----------------------------------------------------------------
	assign loop_on   = ctl[CTL_LOOP_BIT];
	// loopback feeds rts (low active) back into cts; pin parks high
	assign cts_raw   = loop_on ? ~ctl[CTL_RTS_BIT] : CTS_N_IN;
	assign RTS_N_OUT = loop_on ? 1'b1 : ~ctl[CTL_RTS_BIT];

	cts_sync cts_sync_inst (
		.clk_in     (SYS_CLK_IN),
		.rst_in     (RST_IN),
		.cts_raw_in (cts_raw),
		.cts        (cts.detector)
	);

	rx_tout_timer rx_tout_timer_inst (
		.clk_in   (SYS_CLK_IN),
		.rst_in   (RST_IN),
		.push_in  (RX_PUSH_IN),
		.empty_in (RX_EMPTY_IN),
		.tick_in  (BAUD_TICK_IN),
		.cmp_in   (rx_timeout_reg[TOR_CMP_MSB:0]),
		.hit_out  (tout_hit)
	);

	// ----------------------------------------------------------------
	// axi4-lite handshake
	// ----------------------------------------------------------------
	// address and data may arrive in either order; one write at a time
	assign AWREADY_OUT = !aw_held && !bvalid;
	assign WREADY_OUT  = !w_held && !bvalid;
	assign ARREADY_OUT = !rvalid;
	assign do_wr = (aw_held || AWVALID_IN) && (w_held || WVALID_IN)
		&& !bvalid;
	assign do_rd = ARVALID_IN && !rvalid;

	// modem interrupt level follows flag and enable combinationally
	assign msi_irq  = chg_flag && irq_enable_reg[IER_MSI_BIT];
	assign msr_read = do_rd && ARADDR_IN == MODEM_STATUS_OFS;

	// next state of the bus slave and of the programmable registers
	always_comb begin
		logic [7:0]  wa;
		logic [31:0] wd;
		wa            = aw_held ? aw_addr : AWADDR_IN;
		wd            = w_held ? w_data : WDATA_IN;
		next_aw_addr  = aw_addr;
		next_aw_held  = aw_held;
		next_w_data   = w_data;
		next_w_held   = w_held;
		next_bvalid   = bvalid && !BREADY_IN;
		next_bresp    = bresp;
		next_rvalid   = rvalid && !RREADY_IN;
		next_rdata    = rdata;
		next_rresp    = rresp;
		next_tor      = rx_timeout_reg;
		next_ier      = irq_enable_reg;
		next_ctl      = ctl;
		next_evt_en   = evt_en;
		evt_clr       = '0;
		if (AWVALID_IN && AWREADY_OUT && !do_wr) begin
			next_aw_addr = AWADDR_IN;
			next_aw_held = 1'b1;
		end
		if (WVALID_IN && WREADY_OUT && !do_wr) begin
			next_w_data = WDATA_IN;
			next_w_held = 1'b1;
		end
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (wa == MODEM_STATUS_OFS) begin
				next_bresp = RESP_OKAY;
			end else if (wa == RX_TIMEOUT_OFS) begin
				if (WSTRB_IN[0] || w_held)
					next_tor = wd[7:0];
			end else if (wa == IRQ_ENABLE_OFS) begin
				next_ier = wd[3:0];
			end else if (wa == CONTROL_OFS) begin
				next_ctl = wd[1:0];
			end else if (wa == EVT_CLEAR_OFS) begin
				evt_clr = wd[EVT_W-1:0];
			end else if (wa == EVT_ENABLE_OFS) begin
				next_evt_en = wd[EVT_W-1:0];
			end else if (wa != EVT_STATUS_OFS) begin
				next_bresp = RESP_SLVERR;
			end
		end
		if (do_rd) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = '0;
			if (ARADDR_IN == MODEM_STATUS_OFS) begin
				next_rdata = MODEM_STATUS_RST;
				next_rdata[MSR_CTS_BIT] = cts.cts_level;
				next_rdata[MSR_CHG_BIT] = chg_flag;
			end else if (ARADDR_IN == RX_TIMEOUT_OFS) begin
				next_rdata[7:0] = rx_timeout_reg;
			end else if (ARADDR_IN == IRQ_ENABLE_OFS) begin
				next_rdata[3:0] = irq_enable_reg;
			end else if (ARADDR_IN == CONTROL_OFS) begin
				next_rdata[1:0] = ctl;
			end else if (ARADDR_IN == EVT_STATUS_OFS) begin
				next_rdata[EVT_W-1:0] = evt_sts;
			end else if (ARADDR_IN == EVT_ENABLE_OFS) begin
				next_rdata[EVT_W-1:0] = evt_en;
			end else if (ARADDR_IN != EVT_CLEAR_OFS) begin
				next_rresp = RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// flags and interrupts
	// ----------------------------------------------------------------
	// a change in the read cycle survives: set wins over the read clear
	always_comb begin
		next_chg_flag = chg_flag;
		if (msr_read)
			next_chg_flag = 1'b0;
		if (cts.cts_changed)
			next_chg_flag = 1'b1;
		next_tout_irq = tout_irq;
		if (RX_PUSH_IN || RX_EMPTY_IN)
			next_tout_irq = 1'b0;
		else if (tout_hit && rx_timeout_reg[TOR_EN_BIT] && irq_enable_reg[IER_TOUT_BIT])
			next_tout_irq = 1'b1;
		if (!(rx_timeout_reg[TOR_EN_BIT] && irq_enable_reg[IER_TOUT_BIT]))
			next_tout_irq = 1'b0;
		evt_set = '0;
		evt_set[EVT_MSI_BIT]  = cts.cts_changed;
		evt_set[EVT_TOUT_BIT] = next_tout_irq && !tout_irq;
		next_evt_sts = (evt_sts & ~evt_clr) | evt_set;
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			aw_addr  <= '0;
			aw_held  <= 1'b0;
			w_data   <= '0;
			w_held   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			rvalid   <= 1'b0;
			rdata    <= '0;
			rresp    <= RESP_OKAY;
			chg_flag <= 1'b0;
			rx_timeout_reg      <= RX_TIMEOUT_RST;
			irq_enable_reg      <= '0;
			ctl      <= '0;
			tout_irq <= 1'b0;
			evt_sts  <= '0;
			evt_en   <= '0;
		end else begin
			aw_addr  <= next_aw_addr;
			aw_held  <= next_aw_held;
			w_data   <= next_w_data;
			w_held   <= next_w_held;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			rvalid   <= next_rvalid;
			rdata    <= next_rdata;
			rresp    <= next_rresp;
			chg_flag <= next_chg_flag;
			rx_timeout_reg      <= next_tor;
			irq_enable_reg      <= next_ier;
			ctl      <= next_ctl;
			tout_irq <= next_tout_irq;
			evt_sts  <= next_evt_sts;
			evt_en   <= next_evt_en;
		end
	end

	// outputs
	assign MSI_IRQ_OUT  = msi_irq;
	assign TOUT_IRQ_OUT = tout_irq;
	assign IRQ_OUT      = |(evt_sts & evt_en);
	assign BVALID_OUT   = bvalid;
	assign BRESP_OUT    = bresp;
	assign RVALID_OUT   = rvalid;
	assign RDATA_OUT    = rdata;
	assign RRESP_OUT    = rresp;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_CTS_BIT: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(do_rd && ARADDR_IN == MODEM_STATUS_OFS) |=>
		RDATA_OUT[MSR_CTS_BIT] == $past(cts.cts_level))
		else $error("msr cts bit not inverted cts");
	AST_CHG_SET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		cts.cts_changed |=> chg_flag)
		else $error("change flag not set");
	AST_CHG_CLR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(msr_read && !cts.cts_changed) |=> !chg_flag)
		else $error("msr read did not clear change flag");
	AST_MSI: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		MSI_IRQ_OUT == (chg_flag && irq_enable_reg[IER_MSI_BIT]))
		else $error("modem interrupt mismatch");
	AST_MSR_WR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(do_wr && (aw_held ? aw_addr : AWADDR_IN) == MODEM_STATUS_OFS)
		|=> $stable(rx_timeout_reg) && $stable(irq_enable_reg) && $stable(ctl))
		else $error("msr write changed state");
	AST_MSR_RSV: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(do_rd && ARADDR_IN == MODEM_STATUS_OFS) |=>
		RDATA_OUT[31:5] == '0 && RDATA_OUT[3:1] == '0)
		else $error("msr reserved bits nonzero");
	AST_TOUT_EN: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		// enable removal takes one edge to drop the registered level
		TOUT_IRQ_OUT |->
		$past(rx_timeout_reg[TOR_EN_BIT] && irq_enable_reg[IER_TOUT_BIT]))
		else $error("time-out interrupt while disabled");
	AST_TOUT_CLR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(RX_PUSH_IN || RX_EMPTY_IN) |=> !TOUT_IRQ_OUT)
		else $error("time-out interrupt not cleared");
	AST_TOUT_SET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(tout_hit && rx_timeout_reg[TOR_EN_BIT] && irq_enable_reg[IER_TOUT_BIT]
		&& !RX_PUSH_IN && !RX_EMPTY_IN) |=> TOUT_IRQ_OUT)
		else $error("time-out interrupt not raised");
	AST_LOOP: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		loop_on |-> RTS_N_OUT)
		else $error("rts pin not parked in loopback");
endmodule // modem_tout_top

// ==== test/cts_partner.sv ====
// remote serial partner model driving the clear-to-send handshake
`timescale 1ns/1ps
module cts_partner (
	input  wire logic clk_in,    // bench clock
	input  wire logic rst_in,    // sync reset, high
	input  wire logic want_in,   // 1 = partner wants cts asserted
	input  wire logic slow_in,   // 1 = answer late
	output logic      cts_n_out  // clear-to-send pin, low active
);
	int wait_cnt;

	// ----------------------------------------
	// handshake response
	// ----------------------------------------
	// follows the wish after two or seven cycles; the pin moves off the
	// clock edge on purpose, since the real partner is asynchronous
	always @(posedge clk_in) begin
		if (rst_in) begin
			cts_n_out <= 1'b1;
			wait_cnt  <= 0;
		end else if (want_in == cts_n_out) begin
			if (wait_cnt >= (slow_in ? 6 : 1)) begin
				cts_n_out <= #1.3 ~want_in;
				wait_cnt  <= 0;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end else begin
			wait_cnt <= 0;
		end
	end
endmodule // cts_partner

// ==== test/modem_tout_top_tb.sv ====
// testbench: modem status and receive time-out block over axi4-lite
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module modem_tout_top_tb
	import msr_tout_pkg::*;
;
	logic        clk, rst, push, empty, tick, want, slow;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rnd;
	logic [3:0]  wstrb;
	wire logic   cts_n, rts_n, msi, tout, irq;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [33:0] rexp;
	logic [1:0]  bexp;
	logic [6:0]  cmp;
	int          n_mismatch, checked;

	// ----------------------------------------
	// clock, partner and design
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	cts_partner cts_partner_inst (.clk_in(clk), .rst_in(rst), .want_in(want),
		.slow_in(slow), .cts_n_out(cts_n));

	modem_tout_top modem_tout_top_inst (.SYS_CLK_IN(clk), .RST_IN(rst),
		.CTS_N_IN(cts_n), .RTS_N_OUT(rts_n), .RX_PUSH_IN(push),
		.RX_EMPTY_IN(empty), .BAUD_TICK_IN(tick), .MSI_IRQ_OUT(msi),
		.TOUT_IRQ_OUT(tout), .IRQ_OUT(irq), .AWADDR_IN(awaddr),
		.AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
		.WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready),
		.BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
		.RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
		.RREADY_IN(rready));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// the extra #1 lets the edge's own updates land before any check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		@(posedge clk);
		bq.push_back(er);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		int n;
		@(posedge clk);
		rq.push_back({er, ed});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			final_report();
		end
	endtask

	task automatic push_word();
		@(posedge clk);
		push  <= 1'b1;
		empty <= 1'b0;
		@(posedge clk);
		push  <= 1'b0;
	endtask

	// random gaps between baud ticks, one to four cycles
	task automatic ticks(input int n);
		repeat (n) begin
			rnd = lfsr(rnd);
			repeat (rnd[1:0] + 1) @(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		#1;
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// response watcher
	// ----------------------------------------
	// answers are matched in issue order against the driver's notes
	always @(posedge clk) begin
		if (rvalid && rready) begin
			rexp = rq.pop_front();
			`CHK({rresp, rdata}, rexp)
		end
		if (bvalid && bready) begin
			bexp = bq.pop_front();
			`CHK(bresp, bexp)
		end
	end

	// a hang counts as a mismatch
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{push, tick, want, slow, awvalid, wvalid, bready} = '0;
		{arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		empty = 1'b1;
		rst = 1'b1;
		rnd = 32'hd5d0;
		n_mismatch = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// reset values, unmapped place, write to read-only status
		rd(MODEM_STATUS_OFS, 32'h0, RESP_OKAY);
		rd(RX_TIMEOUT_OFS, 32'h0, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(MODEM_STATUS_OFS, 32'hffff_ffff, RESP_OKAY);
		rd(MODEM_STATUS_OFS, 32'h0, RESP_OKAY);
		// cts asserted promptly: flag, interrupt, clear on read
		wr(IRQ_ENABLE_OFS, 32'h8, RESP_OKAY);
		wr(EVT_ENABLE_OFS, 32'h1, RESP_OKAY);
		want <= 1'b1;
		cyc(12);
		`CHK(msi, 1'b1)
		`CHK(irq, 1'b1)
		rd(MODEM_STATUS_OFS, 32'h11, RESP_OKAY);
		cyc(1);
		`CHK(msi, 1'b0)
		rd(MODEM_STATUS_OFS, 32'h10, RESP_OKAY);
		rd(EVT_STATUS_OFS, 32'h1, RESP_OKAY);
		wr(EVT_ENABLE_OFS, 32'h0, RESP_OKAY);
		cyc(1);
		`CHK(irq, 1'b0)
		wr(EVT_CLEAR_OFS, 32'h1, RESP_OKAY);
		wr(EVT_ENABLE_OFS, 32'h1, RESP_OKAY);
		cyc(1);
		`CHK(irq, 1'b0)
		rd(EVT_CLEAR_OFS, 32'h0, RESP_OKAY);
		// cts released late: flag again, enable removal drops interrupt
		slow <= 1'b1;
		want <= 1'b0;
		cyc(16);
		`CHK(msi, 1'b1)
		wr(IRQ_ENABLE_OFS, 32'h0, RESP_OKAY);
		cyc(1);
		`CHK(msi, 1'b0)
		rd(MODEM_STATUS_OFS, 32'h01, RESP_OKAY);
		// loopback: rts drives the internal cts, pin held high
		wr(CONTROL_OFS, 32'h3, RESP_OKAY);
		cyc(1);
		`CHK(rts_n, 1'b1)
		cyc(6);
		rd(MODEM_STATUS_OFS, 32'h11, RESP_OKAY);
		wr(CONTROL_OFS, 32'h1, RESP_OKAY);
		cyc(6);
		rd(MODEM_STATUS_OFS, 32'h01, RESP_OKAY);
		wr(CONTROL_OFS, 32'h2, RESP_OKAY);
		cyc(1);
		`CHK(rts_n, 1'b0)
		cyc(6);
		rd(MODEM_STATUS_OFS, 32'h00, RESP_OKAY);
		// receive time-out, compare 0 first then random values
		wr(IRQ_ENABLE_OFS, 32'h9, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			cmp = (i == 0) ? 7'd0 : 7'(rnd % 12) + 7'd1;
			wr(RX_TIMEOUT_OFS, 32'h80 | cmp, RESP_OKAY);
			rd(RX_TIMEOUT_OFS, 32'h80 | cmp, RESP_OKAY);
			push_word();
			if (cmp > 0) begin
				ticks(cmp - 1);
				cyc(3);
				`CHK(tout, 1'b0)
				ticks(1);
			end
			cyc(3);
			`CHK(tout, 1'b1)
			ticks(3);
			`CHK(tout, 1'b1)
			if (i[0]) push_word();
			else empty <= 1'b1;
			cyc(3);
			`CHK(tout, 1'b0)
		end
		// either enable missing keeps the time-out silent
		wr(IRQ_ENABLE_OFS, 32'h8, RESP_OKAY);
		push_word();
		ticks(8);
		`CHK(tout, 1'b0)
		wr(IRQ_ENABLE_OFS, 32'h9, RESP_OKAY);
		wr(RX_TIMEOUT_OFS, 32'h05, RESP_OKAY);
		push_word();
		ticks(8);
		`CHK(tout, 1'b0)
		// enable taken away while the interrupt stands
		wr(RX_TIMEOUT_OFS, 32'h82, RESP_OKAY);
		push_word();
		ticks(2);
		cyc(3);
		`CHK(tout, 1'b1)
		wr(RX_TIMEOUT_OFS, 32'h02, RESP_OKAY);
		cyc(2);
		`CHK(tout, 1'b0)
		cyc(4);
		final_report();
	end
endmodule // modem_tout_top_tb
